// file: flash_array_model.sv
// behavioural model of the flash array behind the controller
`timescale 1ns/1ps
module flash_array_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic op_start_i,
    input wire logic [7:0] op_cmd_i,
    output logic blank_o,
    output logic fail_o
);
    logic erased_r;
    // mass erase wipes the array, word program dirties it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            erased_r <= 1'b1;
        else if (op_start_i && op_cmd_i == 8'h41)
            erased_r <= 1'b1;
        else if (op_start_i && op_cmd_i == 8'h20)
            erased_r <= 1'b0;
    end
    assign blank_o = erased_r;
    assign fail_o = 1'b0;
endmodule // flash_array_model

// file: flash_clk_div.sv
// flash clock tick generator
`timescale 1ns/1ps
`include "flash_defs.svh"
module flash_clk_div (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic prescale_i,
    input wire logic [5:0] divide_i,
    output logic tick_o
);
    import flash_pkg::*;
    div_state_t st_r;
    div_state_t st_nxt;
    logic [9:0] ratio;
    always_comb
    begin
        // prescaler multiplies the divide ratio by eight
        ratio = {4'h0, divide_i} + 10'h001;
        if (prescale_i)
        begin
            ratio = ratio * {1'b0, `DIV_PRE_RATIO};
        end
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!enable_i)
        begin
            st_nxt.cnt = 9'h000;
        end
        else if ({1'b0, st_r.cnt} + 10'h001 >= ratio)
        begin
            st_nxt.cnt = 9'h000;
            st_nxt.tick = 1'b1;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + 9'h001;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign tick_o = st_r.tick;
endmodule // flash_clk_div

// file: flash_command_controller.sv
// flash command controller with wishbone register slave
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`include "flash_defs.svh"
module flash_command_controller (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] sec_byte_i,
    input wire logic [63:0] key_data_i,
    input wire logic array_blank_i,
    input wire logic array_fail_i,
    input wire logic special_mode_i,
    input wire logic debug_mode_i,
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    output logic irq_o,
    output logic hv_on_o,
    output logic op_start_o,
    output logic [7:0] op_cmd_o,
    output logic [15:0] op_addr_o,
    output logic secured_o
);
    import flash_pkg::*;
    ctl_state_t st_r;
    ctl_state_t st_nxt;
    logic tick;
    logic busy;
    logic done;
    logic abort;
    logic wr;
    logic rd;
    logic [3:0] idx;
    logic launch;
    logic bad_cmd;
    logic prot_hit;
    logic fetch;

    function automatic logic cmd_legal(input logic [7:0] c);
        cmd_legal = (c == `CMD_ERASE_VERIFY) || (c == `CMD_WORD_PROGRAM)
            || (c == `CMD_SECTOR_ERASE) || (c == `CMD_MASS_ERASE);
    endfunction

    flash_clk_div u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(st_r.clkdiv[`DIV_LOADED]),
        .prescale_i(st_r.clkdiv[`DIV_PRESCALE]),
        .divide_i(st_r.clkdiv[5:0]),
        .tick_o(tick)
    );

    flash_op_timer u_tmr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .start_i(st_r.start),
        .abort_i(abort),
        .cmd_i(st_r.act_cmd),
        .busy_o(busy),
        .done_o(done)
    );

    assign idx = wb_adr_i[5:2];
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && st_r.ack;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !st_r.ack;
    assign abort = stop_mode_i && !st_r.stop_q && st_r.act;
    // protected sectors sit at or above the boundary field
    assign prot_hit = st_r.prot[`PROT_EN]
        && (st_r.addr[15:10] >= st_r.prot[5:0]);
    assign bad_cmd = !cmd_legal(st_r.cmd) || !st_r.clkdiv[`DIV_LOADED]
        || (st_r.secured && special_mode_i && debug_mode_i
        && st_r.cmd != `CMD_MASS_ERASE);
    assign launch = wr && idx == `IDX_STAT && wb_sel_i[0]
        && wb_dat_i[`ST_BUFFER_EMPTY_FLAG] && st_r.seq == SEQ_CMD && !stop_mode_i;
    assign fetch = st_r.pend && !st_r.act && !stop_mode_i;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.start = 1'b0;
        st_nxt.stop_q = stop_mode_i;
        st_nxt.ack = wb_cyc_i && wb_stb_i && !st_r.ack;
        if (!st_r.sec_loaded)
        begin
            st_nxt.sec = sec_byte_i;
            st_nxt.sec_loaded = 1'b1;
            st_nxt.unsec = 1'b0;
        end
        if (rd)
        begin
            unique case (idx)
                `IDX_CLKDIV: st_nxt.dat = {8'h00, st_r.clkdiv};
                `IDX_SEC: st_nxt.dat = {8'h00, st_r.sec};
                `IDX_CFG: st_nxt.dat = {8'h00, st_r.cfg};
                `IDX_PROT: st_nxt.dat = {8'h00, st_r.prot};
                `IDX_STAT: st_nxt.dat = {8'h00, st_r.buffer_empty_flag, st_r.command_complete_flag,
                    st_r.protection_violation_flag, st_r.access_error_flag, 1'b0, st_r.blank,
                    special_mode_i && st_r.fail,
                    special_mode_i && !st_r.act && !st_r.pend};
                `IDX_CMD: st_nxt.dat = {8'h00, st_r.cmd};
                `IDX_ADDR: st_nxt.dat = st_r.addr;
                default: st_nxt.dat = 16'h0000;
            endcase
        end
        if (wr && wb_sel_i[0])
        begin
            unique case (idx)
                `IDX_CLKDIV:
                begin
                    if (!st_r.clkdiv[`DIV_LOADED])
                    begin
                        st_nxt.clkdiv = {1'b1, wb_dat_i[6:0]};
                    end
                end
                `IDX_CFG: st_nxt.cfg = {wb_dat_i[7:5], 5'h00};
                `IDX_PROT:
                begin
                    if (debug_mode_i)
                    begin
                        st_nxt.prot = wb_dat_i[7:0];
                    end
                end
                `IDX_STAT:
                begin
                    if (wb_dat_i[`ST_PROTECTION_VIOLATION_FLAG])
                    begin
                        st_nxt.protection_violation_flag = 1'b0;
                    end
                    if (wb_dat_i[`ST_ACCESS_ERROR_FLAG])
                    begin
                        st_nxt.access_error_flag = 1'b0;
                    end
                    if (special_mode_i && wb_dat_i[`ST_FAIL])
                    begin
                        st_nxt.fail = 1'b0;
                    end
                    if (!wb_dat_i[`ST_BUFFER_EMPTY_FLAG] && st_r.seq != SEQ_IDLE)
                    begin
                        st_nxt.access_error_flag = 1'b1;
                        st_nxt.seq = SEQ_IDLE;
                    end
                end
                `IDX_CMD:
                begin
                    if (st_r.seq == SEQ_ADDR)
                    begin
                        st_nxt.cmd = wb_dat_i[7:0];
                        st_nxt.seq = SEQ_CMD;
                    end
                    else
                    begin
                        st_nxt.access_error_flag = 1'b1;
                        st_nxt.seq = SEQ_IDLE;
                    end
                end
                `IDX_ADDR:
                begin
                    st_nxt.addr[7:0] = wb_dat_i[7:0];
                end
                `IDX_DATA:
                begin
                    if (st_r.cfg[`CFG_KEY_ACCESS_BIT]
                        && st_r.sec[7:6] == `SEC_KEY_ENABLE_FIELD_CODE)
                    begin
                        // compare key word in order
                        if (st_r.addr != 16'(`KEY_BASE
                            + {13'h0000, st_r.key_idx, 1'b0})
                            || wb_dat_i[15:0] != key_data_i[
                            {st_r.key_idx, 4'h0} +: 16])
                        begin
                            st_nxt.key_ok = 1'b0;
                        end
                        st_nxt.key_idx = st_r.key_idx + 2'h1;
                        if (st_r.key_idx == 2'h3)
                        begin
                            st_nxt.unsec = st_nxt.key_ok;
                            st_nxt.key_ok = 1'b1;
                        end
                    end
                    else if (st_r.seq == SEQ_IDLE && st_r.buffer_empty_flag)
                    begin
                        st_nxt.seq = SEQ_ADDR;
                    end
                    else
                    begin
                        st_nxt.access_error_flag = 1'b1;
                        st_nxt.seq = SEQ_IDLE;
                    end
                end
                default: ;
            endcase
        end
        if (wr && wb_sel_i[1] && idx == `IDX_ADDR)
        begin
            st_nxt.addr[15:8] = wb_dat_i[15:8];
        end
        if (launch)
        begin
            st_nxt.seq = SEQ_IDLE;
            if (bad_cmd)
            begin
                st_nxt.access_error_flag = 1'b1;
            end
            else if (st_r.cmd == `CMD_SECTOR_ERASE && prot_hit)
            begin
                st_nxt.protection_violation_flag = 1'b1;
            end
            else
            begin
                st_nxt.buffer_empty_flag = 1'b0;
                st_nxt.pend = 1'b1;
                st_nxt.pend_cmd = st_r.cmd;
                st_nxt.pend_addr = st_r.addr;
            end
        end
        if (fetch)
        begin
            st_nxt.pend = launch && !bad_cmd
                && !(st_r.cmd == `CMD_SECTOR_ERASE && prot_hit);
            st_nxt.act = 1'b1;
            st_nxt.act_cmd = st_r.pend_cmd;
            st_nxt.op_addr = st_r.pend_cmd == `CMD_SECTOR_ERASE
                ? {st_r.pend_addr[15:10], 10'h000} : st_r.pend_addr;
            st_nxt.start = 1'b1;
            st_nxt.hv = 1'b1;
            st_nxt.buffer_empty_flag = !st_nxt.pend;
            if (st_r.pend_cmd == `CMD_ERASE_VERIFY)
            begin
                st_nxt.blank = 1'b0;
            end
        end
        if (done)
        begin
            st_nxt.act = 1'b0;
            st_nxt.hv = 1'b0;
            if (st_r.act_cmd == `CMD_ERASE_VERIFY)
            begin
                st_nxt.blank = array_blank_i;
            end
            if (array_fail_i)
            begin
                st_nxt.fail = 1'b1;
            end
            st_nxt.command_complete_flag = !st_nxt.pend;
        end
        if (abort)
        begin
            st_nxt.act = 1'b0;
            st_nxt.pend = 1'b0;
            st_nxt.hv = 1'b0;
            st_nxt.command_complete_flag = 1'b1;
            st_nxt.access_error_flag = 1'b1;
        end
        if (!stop_mode_i && st_r.stop_q)
        begin
            st_nxt.buffer_empty_flag = 1'b1;
            st_nxt.pend = 1'b0;
            st_nxt.seq = SEQ_IDLE;
        end
        if (!st_nxt.buffer_empty_flag && !stop_mode_i)
        begin
            st_nxt.command_complete_flag = 1'b0;
        end
        st_nxt.secured = (st_nxt.sec[1:0] != `SEC_UNSEC_CODE) && !st_nxt.unsec;
        st_nxt.irq = (st_nxt.buffer_empty_flag && st_nxt.cfg[`CFG_BUFFER_EMPTY_IRQ_ENABLE])
            || (st_nxt.command_complete_flag && st_nxt.cfg[`CFG_COMPLETE_IRQ_ENABLE]);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r <= '0;
            st_r.seq <= SEQ_IDLE;
            st_r.sec <= `SEC_RESET;
            st_r.buffer_empty_flag <= 1'b1;
            st_r.command_complete_flag <= 1'b1;
            st_r.key_ok <= 1'b1;
            st_r.secured <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = {16'h0000, st_r.dat};
    assign irq_o = st_r.irq;
    assign hv_on_o = st_r.hv;
    assign op_start_o = st_r.start;
    assign op_cmd_o = st_r.act_cmd;
    assign op_addr_o = st_r.op_addr;
    assign secured_o = st_r.secured;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    AST_BAD_CODE: assert property (launch && !cmd_legal(st_r.cmd)
        |=> st_r.access_error_flag && !op_start_o)
        else $error("illegal code not flagged");
    AST_PROT: assert property (launch && !bad_cmd && prot_hit
        && st_r.cmd == `CMD_SECTOR_ERASE |=> st_r.protection_violation_flag ##1 !op_start_o)
        else $error("protected sector erase launched");
    AST_COMMAND_COMPLETE_FLAG_LOW: assert property (!st_r.buffer_empty_flag && !st_r.stop_q
        && !stop_mode_i |-> !st_r.command_complete_flag)
        else $error("complete set while buffer busy");
    AST_DIV_ONCE: assert property (st_r.clkdiv[`DIV_LOADED]
        |=> $stable(st_r.clkdiv))
        else $error("divider changed after load");
    AST_SEC_HOLD: assert property (st_r.sec_loaded
        |=> $stable(st_r.sec))
        else $error("security register changed");
    AST_STOP_ABORT: assert property (abort
        |=> st_r.command_complete_flag && st_r.access_error_flag && !hv_on_o && !busy)
        else $error("stop abort incomplete");
    AST_BLANK: assert property (done && st_r.act_cmd == `CMD_ERASE_VERIFY
        && !array_blank_i |=> !st_r.blank)
        else $error("blank set on unerased array");
    AST_DONE_COMMAND_COMPLETE_FLAG: assert property (done && !st_r.pend && !launch
        && !abort |=> st_r.command_complete_flag)
        else $error("complete not set");
    AST_CBE_ZERO: assert property (wr && wb_sel_i[0] && idx == `IDX_STAT
        && !wb_dat_i[`ST_BUFFER_EMPTY_FLAG] && st_r.seq != SEQ_IDLE
        |=> st_r.access_error_flag && st_r.seq == SEQ_IDLE)
        else $error("abort by zero write missing");
    AST_RSVD: assert property (rd && idx == `IDX_RSVD
        |=> wb_ack_o && wb_dat_o == 32'h00000000)
        else $error("reserved location not zero");
    AST_START_TIMER: assert property (op_start_o |=> busy [*2])
        else $error("operation not running");
    AST_WAIT_RUN: assert property (wait_mode_i && fetch |=> op_start_o)
        else $error("buffered work stalled in wait");

    COV_LAUNCH: cover property (launch ##[1:20] op_start_o);
    COV_BUFFERED: cover property (st_r.act && st_r.pend);
    COV_STOP: cover property (abort);
    COV_UNSEC: cover property ($rose(st_r.unsec));
endmodule // flash_command_controller

// file: flash_command_controller_tb.sv
// self-checking testbench of the flash command controller
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((e) !== (a)) begin \
    fail_count++; $display("Error %s expected %h seen %h", n, e, a); end end
module flash_command_controller_tb;
    import flash_pkg::*;
    localparam logic [63:0] KEY = 64'h1234_5678_9abc_def0; // arbitrary
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, spc = 0;
    logic [5:0] adr = 0;
    logic [3:0] sel = 0;
    logic [31:0] dat = 0, rdat, last_q;
    logic ack, blank, fail, dbg = 0, wt = 0, stp = 0, irq, hv, ops, sec_o;
    logic [7:0] op_cmd;
    logic [15:0] op_addr, a;
    logic [7:0] codes [3] = '{8'h41, 8'h20, 8'h40};
    logic [7:0] msk_q [$], exp_q [$];
    logic [23:0] op_q [$];
    int fail_count = 0, checks = 0, cycles = 0, seed = 53;
    always #50 clk_i = ~clk_i;
    flash_command_controller dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sec_byte_i(8'h80), .key_data_i(KEY), .array_blank_i(blank),
        .array_fail_i(fail), .special_mode_i(spc), .debug_mode_i(dbg),
        .wait_mode_i(wt), .stop_mode_i(stp), .irq_o(irq), .hv_on_o(hv),
        .op_start_o(ops), .op_cmd_o(op_cmd), .op_addr_o(op_addr),
        .secured_o(sec_o));
    flash_array_model model (.clk_i(clk_i), .rst_i(rst_i),
        .op_start_i(ops), .op_cmd_i(op_cmd), .blank_o(blank),
        .fail_o(fail));
    task automatic end_of_test();
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] i,
                       input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        sel <= 4'h3;
        dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        last_q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] i, input logic [7:0] m,
                      input logic [7:0] v);
        msk_q.push_back(m);
        exp_q.push_back(v);
        bus(1'b0, i, 32'h0);
    endtask
    task automatic seq(input logic [15:0] ad, input logic [7:0] c);
        bus(1'b1, 4'h8, {16'h0, ad});
        bus(1'b1, 4'ha, $random(seed));
        bus(1'b1, 4'h6, {24'h0, c});
        bus(1'b1, 4'h5, 32'h80);
    endtask
    task automatic wait_cc();
        rd(4'h5, 8'h00, 8'h00);
        while (last_q[6] !== 1'b1)
            rd(4'h5, 8'h00, 8'h00);
    endtask
    // read results and operation starts checked against the notes
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles > 50000)
        begin
            fail_count++;
            end_of_test();
        end
    end
    always @(posedge clk_i)
    begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
        begin
            `CHK("rdata", exp_q[0], rdat[7:0] & msk_q[0])
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        if (ops === 1'b1)
        begin
            `CHK("op_start", 1'b1, op_q.size() > 0)
            if (op_q.size() > 0)
            begin
                `CHK("op_cmd", op_q[0][23:16], op_cmd)
                if (op_q[0][23:16] == 8'h40)
                    `CHK("op_addr", op_q[0][15:0], op_addr)
                void'(op_q.pop_front());
            end
        end
    end
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(4'h1, 8'hff, 8'h80);
        bus(1'b1, 4'h1, 32'hff);
        rd(4'h1, 8'hff, 8'h80);
        `CHK("secured", 1'b1, sec_o)
        `CHK("irq", 1'b0, irq)
        rd(4'h5, 8'hff, 8'hc0);
        rd(4'h0, 8'hff, 8'h00);
        bus(1'b1, 4'h0, 32'h46);
        rd(4'h0, 8'hff, 8'hc6);
        bus(1'b1, 4'h0, 32'h7f);
        rd(4'h0, 8'hff, 8'hc6);
        bus(1'b1, 4'h7, 32'hff);
        rd(4'h7, 8'hff, 8'h00);
        rd(4'hf, 8'hff, 8'h00);
        dbg <= 1'b1;
        bus(1'b1, 4'h4, 32'hbe);
        dbg <= 1'b0;
        rd(4'h4, 8'hff, 8'hbe);
        op_q.push_back({8'h05, 16'h0});
        seq(16'h4000, 8'h05);
        wait_cc();
        rd(4'h5, 8'hff, 8'hc4);
        spc <= 1'b1;
        dbg <= 1'b1;
        seq(16'h4000, 8'h05);
        rd(4'h5, 8'h10, 8'h10);
        bus(1'b1, 4'h5, 32'h12);
        rd(4'h5, 8'h13, 8'h01);
        spc <= 1'b0;
        dbg <= 1'b0;
        wt <= 1'b1;
        foreach (codes[k])
        begin
            a = {1'b0, 15'($random(seed))};
            op_q.push_back({codes[k], a & 16'hfc00});
            seq(a, codes[k]);
            rd(4'h5, 8'h40, 8'h00);
            wait_cc();
            rd(4'h5, 8'hf0, 8'hc0);
        end
        wt <= 1'b0;
        op_q.push_back({8'h05, 16'h0});
        seq(16'h4000, 8'h05);
        wait_cc();
        rd(4'h5, 8'h04, 8'h00);
        seq(16'h4000, 8'h33);
        rd(4'h5, 8'h10, 8'h10);
        bus(1'b1, 4'h5, 32'h10);
        seq(16'hfc00, 8'h40);
        rd(4'h5, 8'h30, 8'h20);
        bus(1'b1, 4'h5, 32'h20);
        bus(1'b1, 4'h8, 32'h4000);
        bus(1'b1, 4'ha, 32'h0);
        bus(1'b1, 4'h6, 32'h20);
        bus(1'b1, 4'h5, 32'h00);
        rd(4'h5, 8'h10, 8'h10);
        bus(1'b1, 4'h5, 32'h10);
        bus(1'b1, 4'h5, 32'h00);
        rd(4'h5, 8'h90, 8'h80);
        op_q.push_back({8'h20, 16'h0});
        seq(16'h4000, 8'h20);
        repeat (6) @(posedge clk_i);
        `CHK("hv_on", 1'b1, hv)
        stp <= 1'b1;
        repeat (3) @(posedge clk_i);
        `CHK("hv_on", 1'b0, hv)
        rd(4'h5, 8'h50, 8'h50);
        stp <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd(4'h5, 8'h80, 8'h80);
        bus(1'b1, 4'h5, 32'h10);
        rd(4'h5, 8'h10, 8'h00);
        bus(1'b1, 4'h3, 32'he0);
        repeat (2) @(posedge clk_i);
        `CHK("irq", 1'b1, irq)
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, 4'h8, 32'hff00 + 2 * k);
            bus(1'b1, 4'ha, {16'h0, KEY[16 * k +: 16]});
        end
        repeat (3) @(posedge clk_i);
        `CHK("secured", 1'b0, sec_o)
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        `CHK("secured", 1'b1, sec_o)
        rd(4'h0, 8'hff, 8'h00);
        end_of_test();
    end
endmodule // flash_command_controller_tb

// file: flash_defs.svh
// constants of the flash command controller
`ifndef FLASH_DEFS_SVH
`define FLASH_DEFS_SVH
// register indexes, byte address is four times the index
`define IDX_CLKDIV 4'h0
`define IDX_SEC 4'h1
`define IDX_CFG 4'h3
`define IDX_PROT 4'h4
`define IDX_STAT 4'h5
`define IDX_CMD 4'h6
`define IDX_RSVD 4'h7
`define IDX_ADDR 4'h8
`define IDX_DATA 4'ha
// status bit positions
`define ST_BUFFER_EMPTY_FLAG 7
`define ST_COMMAND_COMPLETE_FLAG 6
`define ST_PROTECTION_VIOLATION_FLAG 5
`define ST_ACCESS_ERROR_FLAG 4
`define ST_BLANK 2
`define ST_FAIL 1
`define ST_DONE 0
// config bit positions
`define CFG_BUFFER_EMPTY_IRQ_ENABLE 7
`define CFG_COMPLETE_IRQ_ENABLE 6
`define CFG_KEY_ACCESS_BIT 5
// divider fields
`define DIV_LOADED 7
`define DIV_PRESCALE 6
`define DIV_PRE_RATIO 9'h008
// command codes
`define CMD_ERASE_VERIFY 8'h05
`define CMD_WORD_PROGRAM 8'h20
`define CMD_SECTOR_ERASE 8'h40
`define CMD_MASS_ERASE 8'h41
// security
`define SEC_RESET 8'h00
`define SEC_UNSEC_CODE 2'h2
`define SEC_KEY_ENABLE_FIELD_CODE 2'h2
`define KEY_BASE 16'hff00
`define PROT_EN 7
// operation lengths in flash clock ticks
`define T_VERIFY 16'h0010
`define T_PROGRAM 16'h0020
`define T_SECTOR 16'h0080
`define T_MASS 16'h0100
`endif

// file: flash_op_timer.sv
// duration counter of one array operation
`timescale 1ns/1ps
`include "flash_defs.svh"
module flash_op_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic [7:0] cmd_i,
    output logic busy_o,
    output logic done_o
);
    import flash_pkg::*;
    tmr_state_t st_r;
    tmr_state_t st_nxt;
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (abort_i)
        begin
            st_nxt.busy = 1'b0;
        end
        else if (start_i)
        begin
            st_nxt.busy = 1'b1;
            unique case (cmd_i)
                `CMD_ERASE_VERIFY: st_nxt.cnt = `T_VERIFY;
                `CMD_WORD_PROGRAM: st_nxt.cnt = `T_PROGRAM;
                `CMD_SECTOR_ERASE: st_nxt.cnt = `T_SECTOR;
                default: st_nxt.cnt = `T_MASS;
            endcase
        end
        else if (st_r.busy && tick_i)
        begin
            if (st_r.cnt <= 16'h0001)
            begin
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
            end
            st_nxt.cnt = st_r.cnt - 16'h0001;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign busy_o = st_r.busy;
    assign done_o = st_r.done;
endmodule // flash_op_timer

// file: flash_pkg.sv
// types of the flash command controller
package flash_pkg;
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_ADDR = 3'b010,
        SEQ_CMD = 3'b100
    } seq_state_t;
    typedef struct packed {
        seq_state_t seq;
        logic [7:0] clkdiv;
        logic [7:0] sec;
        logic sec_loaded;
        logic unsec;
        logic secured;
        logic [7:0] cfg;
        logic [7:0] prot;
        logic buffer_empty_flag;
        logic command_complete_flag;
        logic protection_violation_flag;
        logic access_error_flag;
        logic blank;
        logic fail;
        logic [7:0] cmd;
        logic [15:0] addr;
        logic act;
        logic [7:0] act_cmd;
        logic pend;
        logic [7:0] pend_cmd;
        logic [15:0] pend_addr;
        logic [15:0] op_addr;
        logic [1:0] key_idx;
        logic key_ok;
        logic stop_q;
        logic ack;
        logic [15:0] dat;
        logic irq;
        logic hv;
        logic start;
    } ctl_state_t;
    typedef struct packed {
        logic [8:0] cnt;
        logic tick;
    } div_state_t;
    typedef struct packed {
        logic busy;
        logic [15:0] cnt;
        logic done;
    } tmr_state_t;
endpackage
